// File: converter_fault_supervisor.sv
// fault supervisor: thresholds, trip delays, fault types, warning and power good
`timescale 1ns/10ps
module converter_fault_supervisor #(
    parameter int OT_DELAY = fault_supervisor_pkg::OT_DELAY_CYCLES,
    parameter int RETRY_PERIOD = fault_supervisor_pkg::RETRY_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurements from the converter, same clock
    input wire logic [15:0] vout_mv,
    input wire logic [7:0] iout_pct,
    input wire logic signed [7:0] temp_c,
    input wire logic signed [15:0] track_err_mv,
    input wire logic ramp_active,
    // power stage and system
    output logic stage_off,
    output logic output_window_ok_pin,
    output logic irq
);
    import fault_supervisor_pkg::*;

    typedef enum logic [1:0] {st_off, st_run, st_retry, st_latched} sup_state_type;

    sup_state_type state;
    logic [6:0] ctrl;
    logic [3:0] oc_code;
    logic [1:0] ov_code;
    logic [1:0] uv_code;
    logic pg_code;
    logic [15:0] setpoint_mv;
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_mask;
    logic [31:0] retry_count;
    logic ot_active;
    logic warn_raw;
    logic warn_prev;
    logic pg_prev;
    logic reenable;

    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic [31:0] next_rdata;

    logic [7:0] oc_pct;
    logic [7:0] ov_pct;
    logic [7:0] uv_pct;
    logic [7:0] pg_low_pct;
    logic [23:0] vout_x100;
    logic [23:0] ov_level;
    logic [23:0] ov_floored;
    logic [23:0] uv_level;
    logic [23:0] pg_low_level;
    logic [23:0] pg_high_level;
    logic [15:0] track_abs;

    logic [2:0] slow_raw;
    logic [2:0] slow_q;
    logic oc_raw;
    logic oc_q;
    logic ot_raw;
    logic ot_q;
    logic warn_q;
    logic pg_raw;
    logic [NUM_FAULTS-1:0] trip;
    logic [NUM_FAULTS-1:0] latch_type;
    logic any_trip;
    logic latch_trip;
    logic fault_present;
    logic [NUM_EVENTS-1:0] events;

    // apb decode: writes land at the access edge, reads are fetched in setup
    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    always_comb begin
        addr_ok = 1'b1;
        unique case (paddr)
            CTRL_ADDR, THRESH_ADDR, STATUS_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR, SETPOINT_ADDR: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok; // unmapped address answers with an error

    // read mux, registered so prdata comes from a flip-flop in the access phase
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (paddr)
            CTRL_ADDR: next_rdata = {25'h0, ctrl};
            THRESH_ADDR: next_rdata = {19'h0, pg_code, 2'h0, uv_code, 2'h0, ov_code, oc_code};
            STATUS_ADDR: next_rdata = {19'h0, trip, 2'h0, ot_active, warn_q, output_window_ok_pin,
                                       state == st_retry, state == st_latched, state == st_run};
            IRQ_STATUS_ADDR: next_rdata = {25'h0, irq_status};
            IRQ_MASK_ADDR: next_rdata = {25'h0, irq_mask};
            SETPOINT_ADDR: next_rdata = {16'h0, setpoint_mv};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= next_rdata;
        end
    end

    // control register; writing enable as one is the explicit re-enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            reenable <= 1'b0;
        end else if (wr_en && paddr == CTRL_ADDR) begin
            ctrl <= pwdata[6:0];
            reenable <= pwdata[CTRL_ENABLE_BIT];
        end else begin
            reenable <= 1'b0;
        end
    end

    // threshold codes, clamped to the legal settings on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_code <= OC_CODE_RESET;
            ov_code <= OV_CODE_RESET;
            uv_code <= UV_CODE_RESET;
            pg_code <= PG_CODE_RESET;
        end else if (wr_en && paddr == THRESH_ADDR) begin
            oc_code <= (pwdata[OC_CODE_LSB +: 4] > OC_CODE_MAX) ? OC_CODE_MAX : pwdata[OC_CODE_LSB +: 4];
            ov_code <= (pwdata[OV_CODE_LSB +: 2] > OV_CODE_MAX) ? OV_CODE_MAX : pwdata[OV_CODE_LSB +: 2];
            uv_code <= pwdata[UV_CODE_LSB +: 2];
            pg_code <= pwdata[PG_CODE_BIT];
        end
    end

    // output setpoint that the overvoltage, undervoltage and power good thresholds scale from
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setpoint_mv <= SETPOINT_RESET;
        end else if (wr_en && paddr == SETPOINT_ADDR) begin
            setpoint_mv <= pwdata[15:0];
        end
    end

    // percentages from codes
    assign oc_pct = OC_PCT_MIN + 8'(oc_code) * OC_PCT_STEP;
    assign ov_pct = OV_PCT_MIN + 8'(ov_code) * OV_PCT_STEP;
    assign uv_pct = UV_PCT_MIN + 8'(uv_code) * UV_PCT_STEP;
    assign pg_low_pct = PG_LOW_PCT_MIN + 8'(pg_code) * PG_LOW_PCT_STEP;

    // compare in hundredths so no divider is needed
    assign vout_x100 = 24'(vout_mv) * 24'(PCT_FULL);
    assign ov_level = 24'(setpoint_mv) * 24'(ov_pct);
    assign ov_floored = (ov_level < OV_FLOOR_X100) ? OV_FLOOR_X100 : ov_level;
    assign uv_level = 24'(setpoint_mv) * 24'(uv_pct);
    assign pg_low_level = 24'(setpoint_mv) * 24'(pg_low_pct);
    assign pg_high_level = 24'(setpoint_mv) * 24'(PG_HIGH_PCT);
    assign track_abs = track_err_mv[15] ? 16'(-track_err_mv) : 16'(track_err_mv);

    // raw comparisons; undervoltage is ignored while the output is still ramping
    assign oc_raw = iout_pct > oc_pct;
    assign slow_raw[0] = vout_x100 > ov_floored;
    assign slow_raw[1] = (state == st_run) && !ramp_active && (vout_x100 < uv_level);
    assign slow_raw[2] = (state == st_run) && ramp_active && ctrl[CTRL_TRK_ENABLE_BIT]
                         && (track_abs > TRK_LIMIT_MV);
    assign ot_raw = temp_c >= OT_TRIP_C;
    assign pg_raw = (vout_x100 >= pg_low_level) && (vout_x100 <= pg_high_level);

    // voltage and tracking trips share the 6 us delay
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_slow
            level_qualifier #(.COUNT(FAULT_DELAY_CYCLES)) u_qual (
                .pclk(pclk),
                .presetn(presetn),
                .raw(slow_raw[g]),
                .qualified(slow_q[g])
            );
        end
    endgenerate

    // overcurrent acts on the next edge
    level_qualifier #(.COUNT(OC_DELAY_CYCLES)) u_oc_qual (
        .pclk(pclk),
        .presetn(presetn),
        .raw(oc_raw),
        .qualified(oc_q)
    );

    // overtemperature shutdown delay
    level_qualifier #(.COUNT(OT_DELAY)) u_ot_qual (
        .pclk(pclk),
        .presetn(presetn),
        .raw(ot_raw),
        .qualified(ot_q)
    );

    // warning flag delay
    level_qualifier #(.COUNT(FAULT_DELAY_CYCLES)) u_warn_qual (
        .pclk(pclk),
        .presetn(presetn),
        .raw(warn_raw),
        .qualified(warn_q)
    );

    // power good delay, both directions
    level_qualifier #(.COUNT(FAULT_DELAY_CYCLES)) u_pg_qual (
        .pclk(pclk),
        .presetn(presetn),
        .raw(pg_raw),
        .qualified(output_window_ok_pin)
    );

    // overtemperature holds until the junction cools to the restart level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ot_active <= 1'b0;
        end else if (ot_q) begin
            ot_active <= 1'b1;
        end else if (temp_c <= OT_RESTART_C) begin
            ot_active <= 1'b0;
        end
    end

    // warning level with hysteresis; no enable, it always runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_raw <= 1'b0;
        end else if (temp_c >= OT_WARN_C) begin
            warn_raw <= 1'b1;
        end else if (temp_c <= OT_WARN_C - OT_WARN_HYST_C) begin
            warn_raw <= 1'b0;
        end
    end

    // undervoltage and tracking are compared only in the run state; the other trips form in every state
    assign trip[FLT_OC] = oc_q;
    assign trip[FLT_OV] = slow_q[0];
    assign trip[FLT_UV] = slow_q[1];
    assign trip[FLT_OT] = ot_active;
    assign trip[FLT_TRK] = slow_q[2];
    assign latch_type = ctrl[CTRL_LATCH_LSB +: NUM_FAULTS];
    assign any_trip = |trip;
    assign latch_trip = |(trip & latch_type);
    // undervoltage and tracking cannot be judged with the stage off, so retry ignores them
    assign fault_present = trip[FLT_OC] || trip[FLT_OV] || trip[FLT_OT];

    // supervisor state; stage_off is the turn-off command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_off;
        end else if (!ctrl[CTRL_ENABLE_BIT]) begin
            state <= st_off;
        end else begin
            unique case (state)
                st_off: state <= st_run;
                st_run: begin
                    if (latch_trip) begin
                        state <= st_latched;
                    end else if (any_trip) begin
                        state <= st_retry;
                    end
                end
                st_retry: begin
                    if (retry_count == RETRY_PERIOD - 1 && !fault_present) begin
                        state <= st_run;
                    end
                end
                st_latched: begin
                    if (reenable) begin
                        state <= st_run;
                    end
                end
            endcase
        end
    end

    // retry period timer, restarts each period while the fault persists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retry_count <= 32'h0000_0000;
        end else if (state != st_retry || retry_count == RETRY_PERIOD - 1) begin
            retry_count <= 32'h0000_0000;
        end else begin
            retry_count <= retry_count + 32'h0000_0001;
        end
    end

    assign stage_off = (state != st_run);

    // edge history for warning and power good events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_prev <= 1'b0;
            pg_prev <= 1'b0;
        end else begin
            warn_prev <= warn_q;
            pg_prev <= output_window_ok_pin;
        end
    end

    assign events[NUM_FAULTS-1:0] = (state == st_run) ? trip : '0;
    assign events[EV_WARN] = warn_q && !warn_prev;
    assign events[EV_PG] = output_window_ok_pin != pg_prev;

    // sticky status, write one to clear; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else if (wr_en && paddr == IRQ_STATUS_ADDR) begin
            irq_status <= (irq_status & ~pwdata[NUM_EVENTS-1:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    // interrupt mask, same layout
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr_en && paddr == IRQ_MASK_ADDR) begin
            irq_mask <= pwdata[NUM_EVENTS-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);
endmodule

// File: fault_supervisor_pkg.sv
// constants and register map for the converter fault supervisor
package fault_supervisor_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int FAULT_DELAY_NS = 6000;
    localparam int FAULT_DELAY_CYCLES = (FAULT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OT_DELAY_MS = 2;
    localparam int OT_DELAY_CYCLES = (OT_DELAY_MS * 1000000) / CLK_PERIOD_NS;
    localparam int RETRY_PERIOD_MS = 130;
    localparam int RETRY_CYCLES = (RETRY_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
    localparam int OC_DELAY_CYCLES = 1;

    // register byte offsets
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] THRESH_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0C;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h10;
    localparam logic [7:0] SETPOINT_ADDR = 8'h14;

    // control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_TRK_ENABLE_BIT = 1;
    localparam int CTRL_LATCH_LSB = 2;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    // threshold register fields
    localparam int OC_CODE_LSB = 0;
    localparam int OV_CODE_LSB = 4;
    localparam int UV_CODE_LSB = 8;
    localparam int PG_CODE_BIT = 12;
    localparam logic [3:0] OC_CODE_MAX = 4'hA;
    localparam logic [3:0] OC_CODE_RESET = 4'hA;
    localparam logic [1:0] OV_CODE_MAX = 2'h2;
    localparam logic [1:0] OV_CODE_RESET = 2'h2;
    localparam logic [1:0] UV_CODE_MAX = 2'h3;
    localparam logic [1:0] UV_CODE_RESET = 2'h0;
    localparam logic PG_CODE_RESET = 1'b0;

    // threshold scales, percent and millivolt
    localparam logic [7:0] OC_PCT_MIN = 8'h28;
    localparam logic [7:0] OC_PCT_STEP = 8'h0A;
    localparam logic [7:0] OV_PCT_MIN = 8'h6E;
    localparam logic [7:0] OV_PCT_STEP = 8'h0A;
    localparam logic [7:0] UV_PCT_MIN = 8'h4B;
    localparam logic [7:0] UV_PCT_STEP = 8'h05;
    localparam logic [7:0] PG_LOW_PCT_MIN = 8'h5A;
    localparam logic [7:0] PG_LOW_PCT_STEP = 8'h05;
    localparam logic [7:0] PG_HIGH_PCT = 8'h6E;
    localparam logic [7:0] PCT_FULL = 8'h64;
    localparam logic [23:0] OV_FLOOR_X100 = 24'h0186A0;
    localparam logic [15:0] TRK_LIMIT_MV = 16'h00FA;
    localparam logic [15:0] SETPOINT_RESET = 16'h03E8;

    // temperatures in degrees C
    localparam logic signed [7:0] OT_TRIP_C = 8'sh78;
    localparam logic signed [7:0] OT_RESTART_C = 8'sh6E;
    localparam logic signed [7:0] OT_WARN_C = 8'sh78;
    localparam logic signed [7:0] OT_WARN_HYST_C = 8'sh03;

    // fault and interrupt bit positions
    localparam int FLT_OC = 0;
    localparam int FLT_OV = 1;
    localparam int FLT_UV = 2;
    localparam int FLT_OT = 3;
    localparam int FLT_TRK = 4;
    localparam int EV_WARN = 5;
    localparam int EV_PG = 6;
    localparam int NUM_FAULTS = 5;
    localparam int NUM_EVENTS = 7;

endpackage

// File: level_qualifier.sv
// delay filter: output follows input once input has differed for a fixed count
`timescale 1ns/10ps
module level_qualifier #(
    parameter int COUNT = 60
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // level in and qualified level out
    input wire logic raw,
    output logic qualified
);
    localparam int W = (COUNT > 1) ? $clog2(COUNT) : 1;

    logic [W-1:0] count;

    // count while raw disagrees; a glitch shorter than the delay is swallowed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            qualified <= 1'b0;
        end else if (raw == qualified) begin
            count <= '0;
        end else if (count == W'(COUNT - 1)) begin
            count <= '0;
            qualified <= raw;
        end else begin
            count <= count + 1'b1;
        end
    end
endmodule

// File: converter_fault_supervisor_props.sv
// property checker for the fault supervisor ports
`timescale 1ns/10ps
module converter_fault_supervisor_props #(
    parameter int OT_DELAY = 20
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // measurements
    input wire logic [15:0] vout_mv,
    input wire logic [7:0] iout_pct,
    input wire logic signed [7:0] temp_c,
    input wire logic signed [15:0] track_err_mv,
    input wire logic ramp_active,
    // outputs
    input wire logic stage_off,
    input wire logic output_window_ok_pin,
    input wire logic irq
);
    import fault_supervisor_pkg::*;
    localparam int QUAL = 60;
    logic [31:0] ctrl, thr, sp, v100, overvoltage_trip, ocl, ovc, uvc, trc, otc, pgc;
    logic oc_raw, ov_raw, uv_raw, trk_raw, pg_in, mapped;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // shadow of the programmed controls, taken on the slave's write edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 32'h0;
            thr <= 32'h2A;
            sp <= 32'h3E8;
        end else if (psel && penable && pwrite) begin
            case (paddr)
                CTRL_ADDR: ctrl <= pwdata;
                THRESH_ADDR: thr <= pwdata;
                SETPOINT_ADDR: sp <= {16'h0, pwdata[15:0]};
                default: ;
            endcase
        end
    end
    // levels in percent; codes past the top setting act as the top one
    always_comb begin
        ocl = 32'(OC_PCT_MIN) + 32'(OC_PCT_STEP) * ((thr[3:0] > OC_CODE_MAX) ? 32'(OC_CODE_MAX) : 32'(thr[3:0]));
        overvoltage_trip = 32'(OV_PCT_MIN) + 32'(OV_PCT_STEP) * ((thr[5:4] > OV_CODE_MAX) ? 32'(OV_CODE_MAX) : 32'(thr[5:4]));
        v100 = 32'(vout_mv) * 32'(PCT_FULL);
    end
    // compared in hundredths of a millivolt so no rounding creeps in
    assign oc_raw = 32'(iout_pct) > ocl;
    assign ov_raw = v100 > sp * overvoltage_trip && v100 > 32'(OV_FLOOR_X100);
    assign uv_raw = !ramp_active && v100 < sp * (32'(UV_PCT_MIN) + 32'(UV_PCT_STEP) * 32'(thr[9:8]));
    assign trk_raw = ctrl[CTRL_TRK_ENABLE_BIT] && ramp_active
        && (track_err_mv > $signed(TRK_LIMIT_MV) || track_err_mv < -$signed(TRK_LIMIT_MV));
    assign pg_in = v100 <= sp * 32'(PG_HIGH_PCT)
        && v100 >= sp * (32'(PG_LOW_PCT_MIN) + (thr[PG_CODE_BIT] ? 32'(PG_LOW_PCT_STEP) : 32'h0));
    assign mapped = paddr inside {CTRL_ADDR, THRESH_ADDR, STATUS_ADDR, IRQ_STATUS_ADDR, IRQ_MASK_ADDR, SETPOINT_ADDR};
    // consecutive cycles each condition has held while the stage runs; pgc counts pg_in differing from the pin in any state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovc <= 32'h0;
            uvc <= 32'h0;
            trc <= 32'h0;
            otc <= 32'h0;
            pgc <= 32'h0;
        end else begin
            ovc <= (ov_raw && !stage_off) ? ovc + 32'h1 : 32'h0;
            uvc <= (uv_raw && !stage_off) ? uvc + 32'h1 : 32'h0;
            trc <= (trk_raw && !stage_off) ? trc + 32'h1 : 32'h0;
            otc <= (temp_c >= OT_TRIP_C && !stage_off) ? otc + 32'h1 : 32'h0;
            pgc <= (pg_in != output_window_ok_pin) ? pgc + 32'h1 : 32'h0;
        end
    end
    AST_OC_TRIP: assert property ((!stage_off && oc_raw) [*2] |-> ##[1:2] stage_off)
        else $error("overcurrent left the stage on");
    AST_OV_DELAY: assert property (ovc == QUAL + 1 |-> stage_off)
        else $error("overvoltage turn-off late");
    AST_UV_DELAY: assert property (uvc == QUAL + 1 |-> stage_off)
        else $error("undervoltage turn-off late");
    AST_TRK_DELAY: assert property ($rose(trc == QUAL) |=> stage_off)
        else $error("tracking turn-off late");
    AST_OT_DELAY: assert property (otc == OT_DELAY + 2 |-> stage_off)
        else $error("overtemperature turn-off late");
    AST_PG_LATE: assert property (pgc <= QUAL + 1)
        else $error("power good change late");
    AST_PG_EARLY: assert property (!$stable(output_window_ok_pin) |-> $past(pgc) >= QUAL - 1)
        else $error("power good changed too early");
    AST_APB_ERR: assert property (psel && penable |-> pready && (pslverr == !mapped))
        else $error("apb error response wrong");
    cover property (ovc == QUAL + 1);
    cover property ($rose(output_window_ok_pin));
    cover property ($rose(irq));
endmodule

// File: converter_stage_model.sv
// behavioural power stage: output follows the request while on
`timescale 1ns/10ps
module converter_stage_model (
    // clock
    input wire logic pclk,
    // turn-off command and wanted output
    input wire logic stage_off,
    input wire logic [15:0] vout_req,
    // measured output voltage
    output logic [15:0] vout_mv = 16'h0000
);
    // one cycle of lag stands in for the filter; off means discharged
    always @(posedge pclk) begin
        vout_mv <= stage_off ? 16'h0000 : vout_req;
    end
endmodule

// File: converter_fault_supervisor_test.sv
// self-checking bench for the converter fault supervisor
`timescale 1ns/10ps
module converter_fault_supervisor_test;
    import fault_supervisor_pkg::*;
    localparam int OT_D = 20;
    localparam int RP = 50;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] vout_req = 16'h03E8;
    logic [7:0] iout_pct = 8'h00;
    logic signed [7:0] temp_c = 8'sh19;
    logic signed [15:0] track_err_mv = 16'sh0000;
    logic ramp_active = 1'b0;
    logic [31:0] prdata, rd;
    logic [15:0] vout_mv;
    logic pready, pslverr, stage_off, output_window_ok_pin, irq, serr;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int n;
    always #50 pclk = ~pclk;
    converter_fault_supervisor #(.OT_DELAY(OT_D), .RETRY_PERIOD(RP)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vout_mv(vout_mv),
        .iout_pct(iout_pct), .temp_c(temp_c), .track_err_mv(track_err_mv), .ramp_active(ramp_active),
        .stage_off(stage_off), .output_window_ok_pin(output_window_ok_pin), .irq(irq));
    converter_stage_model stage_i (.pclk(pclk), .stage_off(stage_off), .vout_req(vout_req), .vout_mv(vout_mv));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic walk(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // waits for stage_off, or power good when pick is set
    task automatic wait_sig(input logic pick, input logic v, input int lim);
        n = 0;
        while ((pick ? output_window_ok_pin : stage_off) !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic t_regs();
        apb(1'b0, THRESH_ADDR, 32'h0);
        check("thresh", 32'h0000002A, rd);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", 32'h00000001, {rd[30:0], serr});
        apb(1'b1, CTRL_ADDR, 32'h1);
        walk(3);
        check("run", 32'h0, stage_off);
    endtask
    // lowest current level, with the interrupt raised, masked and cleared
    task automatic t_oc();
        apb(1'b1, THRESH_ADDR, 32'h20);
        iout_pct <= 8'h28;
        walk(10);
        check("oc at level", 32'h0, stage_off);
        iout_pct <= 8'h29;
        wait_sig(1'b0, 1'b1, 10);
        check("oc trip", 32'h1, stage_off);
        iout_pct <= 8'h00;
        check("irq masked", 32'h0, irq);
        apb(1'b0, IRQ_STATUS_ADDR, 32'h0);
        check("oc event", 32'h1, rd[FLT_OC]);
        apb(1'b1, IRQ_MASK_ADDR, 32'h1);
        check("irq", 32'h1, irq);
        apb(1'b1, IRQ_STATUS_ADDR, 32'h1);
        check("irq cleared", 32'h0, irq);
        apb(1'b1, THRESH_ADDR, 32'h2A);
        wait_sig(1'b0, 1'b0, 3 * RP);
        check("oc retry", 32'h0, stage_off);
    endtask
    // low setpoint puts the percent level under the absolute floor
    task automatic t_ov();
        apb(1'b1, SETPOINT_ADDR, 32'h1F4);
        apb(1'b1, THRESH_ADDR, 32'h0A);
        walk(80);
        check("ov floor", 32'h0, stage_off);
        vout_req <= 16'h03E9;
        wait_sig(1'b0, 1'b1, 80);
        check("ov delay", 32'h1, n >= 60 && n <= 65);
        vout_req <= 16'h03E8;
        wait_sig(1'b0, 1'b0, 4 * RP);
        check("ov retry", 32'h1, n >= RP && n <= 2 * RP + 6);
        apb(1'b1, SETPOINT_ADDR, 32'h3E8);
        apb(1'b1, THRESH_ADDR, 32'h2A);
    endtask
    task automatic t_uv();
        apb(1'b1, THRESH_ADDR, 32'h32A);
        apb(1'b1, CTRL_ADDR, 32'h11);
        vout_req <= 16'h0384;
        walk(80);
        check("uv at level", 32'h0, stage_off);
        vout_req <= 16'h0383;
        wait_sig(1'b0, 1'b1, 80);
        check("uv delay", 32'h1, n >= 60 && n <= 65);
        vout_req <= 16'h03E8;
        walk(3 * RP);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check("uv latched", 32'h3, {rd[1], stage_off});
        apb(1'b1, CTRL_ADDR, 32'h11);
        walk(2);
        check("uv reenable", 32'h0, stage_off);
        apb(1'b1, CTRL_ADDR, 32'h1);
        apb(1'b1, THRESH_ADDR, 32'h2A);
    endtask
    task automatic t_trk();
        apb(1'b1, CTRL_ADDR, 32'h3);
        track_err_mv <= 16'sh012C;
        walk(80);
        check("trk idle", 32'h0, stage_off);
        ramp_active <= 1'b1;
        track_err_mv <= 16'sh00FA;
        walk(80);
        check("trk at limit", 32'h0, stage_off);
        track_err_mv <= 16'shFF05;
        wait_sig(1'b0, 1'b1, 80);
        check("trk delay", 32'h1, n >= 59 && n <= 64);
        ramp_active <= 1'b0;
        track_err_mv <= 16'sh0000;
        // stale tracking trip outlives one retry
        walk(3 * RP);
        apb(1'b1, CTRL_ADDR, 32'h1);
    endtask
    task automatic t_ot();
        temp_c <= 8'sh78;
        wait_sig(1'b0, 1'b1, 3 * OT_D);
        check("ot delay", 32'h1, n >= OT_D && n <= OT_D + 3);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check("warn early", 32'h0, rd[4]);
        walk(60);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check("warn", 32'h1, rd[4]);
        temp_c <= 8'sh73;
        walk(3 * RP);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check("ot hold warn clear", 32'h1, {rd[4], stage_off});
        temp_c <= 8'sh6E;
        wait_sig(1'b0, 1'b0, 4 * RP);
        check("ot restart", 32'h0, stage_off);
        temp_c <= 8'sh19;
    endtask
    task automatic t_pg();
        apb(1'b1, THRESH_ADDR, 32'h102A);
        vout_req <= 16'h03B5;
        walk(80);
        check("pg below", 32'h0, output_window_ok_pin);
        vout_req <= 16'h03B6;
        wait_sig(1'b1, 1'b1, 100);
        check("pg rise", 32'h1, n >= 58 && n <= 64);
        vout_req <= 16'h044C;
        walk(80);
        check("pg top", 32'h1, output_window_ok_pin);
        vout_req <= 16'h044D;
        wait_sig(1'b1, 1'b0, 100);
        check("pg fall", 32'h1, n >= 58 && n <= 64);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard, well above the fewer than two thousand cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_oc();
        t_ov();
        t_uv();
        t_trk();
        t_ot();
        t_pg();
        complete_run();
    end
endmodule
bind converter_fault_supervisor converter_fault_supervisor_props #(.OT_DELAY(OT_DELAY)) props_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vout_mv(vout_mv),
    .iout_pct(iout_pct), .temp_c(temp_c), .track_err_mv(track_err_mv), .ramp_active(ramp_active),
    .stage_off(stage_off), .output_window_ok_pin(output_window_ok_pin), .irq(irq));
